/* File: include/evc_map.svh */
`ifndef EVC_MAP_SVH
`define EVC_MAP_SVH

// Vector offsets, low twenty address bits of the handler entry
`define EVC_VEC_W       20
`define EVC_VEC_RSVD    20'h00000
`define EVC_VEC_RESET   20'h00100
`define EVC_VEC_MCHK    20'h00200
`define EVC_VEC_DSI     20'h00300
`define EVC_VEC_ISI     20'h00400
`define EVC_VEC_EXT     20'h00500
`define EVC_VEC_ALIGN   20'h00600
`define EVC_VEC_PROG    20'h00700

// Register byte offsets on the AXI4-Lite port
`define EVC_ADDR_W      8
`define EVC_OFS_DFC     8'h00
`define EVC_OFS_CTRL    8'h04
`define EVC_OFS_STAT    8'h08

// Control register fields
`define EVC_CTRL_W      4
`define EVC_CTRL_EE     0
`define EVC_CTRL_LE     1
`define EVC_CTRL_EAE    2
`define EVC_CTRL_FPIMP  3

// Cause bits, numbered from the least significant end
`define EVC_DFC_XLAT    30
`define EVC_DFC_PROT    27
`define EVC_DFC_DSEG    26
`define EVC_DFC_STORE   25
`define EVC_DFC_EXTDIS  20

// Status register: pending flags above the last vector
`define EVC_STAT_PEND   20

// Synchronised pin bank
`define EVC_PIN_W       5
`define EVC_PIN_SRST    0
`define EVC_PIN_HRST    1
`define EVC_PIN_MCHK    2
`define EVC_PIN_TEA     3
`define EVC_PIN_IRQ     4

`define EVC_RESP_OKAY   2'h0
`define EVC_RESP_SLVERR 2'h2

`endif

/* File: include/evc_pkg.sv */
`include "evc_map.svh"

package evc_pkg;

    typedef enum logic [2:0] {
        OP_NONE, OP_SINGLE, OP_FP, OP_MULTIPLE, OP_RESERVE, OP_STRING, OP_EXTCTL, OP_DCBZ
    } evc_op_e;

    typedef enum logic [1:0] {
        CLS_NONE, CLS_ASYNC_NM, CLS_ASYNC_M, CLS_SYNC
    } evc_class_e;

    typedef struct packed {
        logic [`EVC_PIN_W-1:0] s1;
        logic [`EVC_PIN_W-1:0] s2;
    } evc_sync_s;

    typedef struct packed {
        logic [`EVC_ADDR_W-1:0] aw_addr;
        logic                   aw_full;
        logic [31:0]            w_data;
        logic [3:0]             w_strb;
        logic                   w_full;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic [31:0]            dfc;
        logic [`EVC_CTRL_W-1:0] ctrl;
        logic                   rst_prev;
        logic                   mchk_prev;
        logic                   tea_prev;
        logic                   pend_dec;
        logic                   pend_smi;
        logic                   take;
        logic [`EVC_VEC_W-1:0]  vector;
        evc_class_e             cls;
        logic                   precise;
    } evc_state_s;

endpackage

/* File: include/evc_pin_if.sv */
`timescale 1ns/1ns
`include "evc_map.svh"

// Pin levels after the two-stage synchroniser
interface evc_pin_if;
    logic [`EVC_PIN_W-1:0] lvl;
    modport src (output lvl);
    modport dst (input lvl);
endinterface

/* File: hdl/evc_pin_sync.sv */
`timescale 1ns/1ns
`include "evc_map.svh"

module evc_pin_sync (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [`EVC_PIN_W-1:0] raw,
    evc_pin_if.src                     pins
);
    evc_pkg::evc_sync_s s;
    evc_pkg::evc_sync_s next_s;

    // Two flops per pin; only the second stage leaves this module
    always_comb begin
        next_s    = s;
        next_s.s1 = raw;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pins.lvl = s.s2;
endmodule

/* File: hdl/evc_unit.sv */
// Operation
// - External events are asynchronous; machine check and system reset unmaskable and imprecise.
// - Every instruction-caused exception is synchronous and always precise.
// - External, decrementer and management interrupts are maskable asynchronous, handled precisely.
// - Imprecise floating-point mode still delivers enabled fp exceptions precisely.
// - Either reset input takes system reset at 00100; offset 00000 never used.
// - Bus transfer error while the data bus is active, machine-check input or parity error take vector 00200.
// - Data fault cause bit 1 set on translation miss, else cleared.
// - Data fault cause bit 4 set when protection forbids access, else cleared.
// - Cause bit 5 on external-control write-through access or direct-store segment access.
// - Cause bit 6 set for store, cleared for load.
// - Cause bit 11 on external-control access with external access disabled.
// - Untranslatable fetch address takes instruction storage fault at 00400.
// - Fetch forbidden by key and page protection also takes instruction storage fault.
// - External interrupt at 00500 only with enable set and interrupt asserted.
// - Unaligned floating-point load/store operand takes alignment at 00600.
// - Misaligned multiple or reserve/conditional operand takes alignment.
// - Little-endian misaligned single-register load/store takes alignment.
// - Little-endian multiple or string instruction always takes alignment.
// - Cache-line-zero to write-through or cache-inhibited storage takes alignment.
// - Conditions may be seen out of order but are handled in program order.
// - Maskable asynchronous waits for next completion, or restart address when idle.
`timescale 1ns/1ns
`include "evc_map.svh"

module evc_unit #(
    parameter logic [`EVC_VEC_W-1:0] DEC_VECTOR = 20'h00f00,
    parameter logic [`EVC_VEC_W-1:0] SMI_VECTOR = 20'h00e00
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite slave
    input  wire logic [`EVC_ADDR_W-1:0] awaddr,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    input  wire logic [`EVC_ADDR_W-1:0] araddr,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    // Asynchronous pins
    input  wire logic                   soft_reset_in,
    input  wire logic                   hard_reset_in,
    input  wire logic                   machine_check_in,
    input  wire logic                   bus_transfer_error,
    input  wire logic                   irq_in,
    // Core-side events on this clock
    input  wire logic                   data_bus_active,
    input  wire logic                   parity_error,
    input  wire logic                   dec_event,
    input  wire logic                   smi_event,
    input  wire logic                   instr_busy,
    input  wire logic                   restart_known,
    input  wire logic                   user_mode,
    // Completing instruction report
    input  wire logic                   cmp_valid,
    input  wire logic [2:0]             cmp_op,
    input  wire logic                   cmp_store,
    input  wire logic [1:0]             cmp_ea_lo,
    input  wire logic [1:0]             cmp_size,
    input  wire logic                   cmp_xlat_miss,
    input  wire logic                   cmp_prot_deny,
    input  wire logic                   cmp_wt_target,
    input  wire logic                   cmp_direct_seg,
    input  wire logic                   cmp_wt_required,
    input  wire logic                   cmp_cache_inhib,
    input  wire logic                   cmp_fetch_miss,
    input  wire logic                   supervisor_key,
    input  wire logic                   user_key,
    input  wire logic [1:0]             page_protect_bits,
    input  wire logic                   cmp_fp_exc,
    // Exception dispatch
    output logic                        exc_take,
    output logic [`EVC_VEC_W-1:0]       exc_vector,
    output logic [1:0]                  exc_class,
    output logic                        exc_precise
);
    evc_pkg::evc_state_s s;
    evc_pkg::evc_state_s next_s;
    evc_pkg::evc_op_e    op;
    evc_pin_if           pin_bus ();

    logic rst_lvl, rst_edge, mchk_ev, tea_hit;
    logic ee, le, boundary, async_req;
    logic is_ls, word_mis, nat_mis, key;
    logic instr_storage_fault, align, dsi, sync_fault;
    logic want_rst, want_mchk, want_sync, want_async;
    logic [31:0] dfc_word, rd_word;
    logic        rd_err, wr_err;

    // Every pin crosses two flops before use
    evc_pin_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     ({irq_in, bus_transfer_error, machine_check_in,
                   hard_reset_in, soft_reset_in}),
        .pins    (pin_bus.src)
    );

    assign op = evc_pkg::evc_op_e'(cmp_op);
    assign ee = s.ctrl[`EVC_CTRL_EE];
    assign le = s.ctrl[`EVC_CTRL_LE];

    // Asynchronous events, edge-taken so a held pin fires once
    assign rst_lvl  = pin_bus.lvl[`EVC_PIN_SRST] | pin_bus.lvl[`EVC_PIN_HRST];
    assign rst_edge = rst_lvl & ~s.rst_prev;
    assign tea_hit  = pin_bus.lvl[`EVC_PIN_TEA] & ~s.tea_prev & data_bus_active;
    assign mchk_ev  = (pin_bus.lvl[`EVC_PIN_MCHK] & ~s.mchk_prev) | tea_hit
                      | parity_error;

    // Maskable class gated by the enable bit
    assign async_req = ee & (pin_bus.lvl[`EVC_PIN_IRQ] | s.pend_dec | s.pend_smi);
    assign boundary  = cmp_valid | (~instr_busy & restart_known);

    // Instruction storage fault: miss or read-prohibited by key and protection
    assign key = user_mode ? user_key : supervisor_key;
    assign instr_storage_fault = cmp_fetch_miss
                 | (key & (page_protect_bits == 2'h0));

    // Alignment checks
    assign is_ls    = (op != evc_pkg::OP_NONE);
    assign word_mis = |cmp_ea_lo;
    assign nat_mis  = ((cmp_size == 2'h1) & cmp_ea_lo[0]) | ((cmp_size >= 2'h2) & word_mis);
    always_comb begin
        align = 1'b0;
        if ((op == evc_pkg::OP_FP) && word_mis) begin
            align = 1'b1;
        end
        if ((op == evc_pkg::OP_MULTIPLE || op == evc_pkg::OP_RESERVE) && word_mis) begin
            align = 1'b1;
        end
        if (le && (op == evc_pkg::OP_SINGLE) && nat_mis) begin
            align = 1'b1;
        end
        if (le && (op == evc_pkg::OP_MULTIPLE || op == evc_pkg::OP_STRING)) begin
            align = 1'b1;
        end
        if ((op == evc_pkg::OP_DCBZ) && (cmp_wt_required || cmp_cache_inhib)) begin
            align = 1'b1;
        end
    end

    // Cause word for a data storage fault; other bits read back as zero
    always_comb begin
        dfc_word = 32'h0;
        dfc_word[`EVC_DFC_XLAT]   = cmp_xlat_miss;
        dfc_word[`EVC_DFC_PROT]   = cmp_prot_deny;
        dfc_word[`EVC_DFC_DSEG]   = ((op == evc_pkg::OP_EXTCTL) & cmp_wt_target)
                                    | cmp_direct_seg;
        dfc_word[`EVC_DFC_STORE]  = cmp_store;
        dfc_word[`EVC_DFC_EXTDIS] = (op == evc_pkg::OP_EXTCTL)
                                    & ~s.ctrl[`EVC_CTRL_EAE];
    end
    assign dsi = is_ls & (dfc_word[`EVC_DFC_XLAT] | dfc_word[`EVC_DFC_PROT]
                 | dfc_word[`EVC_DFC_DSEG] | dfc_word[`EVC_DFC_EXTDIS]);
    assign sync_fault = instr_storage_fault | align | dsi | cmp_fp_exc;

    // Priority: reset, machine check, then completion order
    assign want_rst   = rst_edge;
    assign want_mchk  = ~rst_edge & mchk_ev;
    assign want_sync  = ~rst_edge & ~mchk_ev & cmp_valid & sync_fault;
    assign want_async = ~rst_edge & ~mchk_ev & ~want_sync & boundary & async_req;

    // Register read mux
    always_comb begin
        rd_word = 32'h0;
        rd_err  = 1'b0;
        unique case (araddr)
            `EVC_OFS_DFC:  rd_word = s.dfc;
            `EVC_OFS_CTRL: rd_word[`EVC_CTRL_W-1:0] = s.ctrl;
            `EVC_OFS_STAT: rd_word = {9'h000, ee & pin_bus.lvl[`EVC_PIN_IRQ], s.pend_smi,
                                      s.pend_dec, s.vector};
            default:       rd_err = 1'b1;
        endcase
    end
    assign wr_err = (s.aw_addr != `EVC_OFS_DFC) && (s.aw_addr != `EVC_OFS_CTRL);

    // Next-state: bus slave, then exception dispatch
    always_comb begin
        next_s      = s;
        next_s.take = 1'b0;
        if (awvalid && !s.aw_full) begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && !s.w_full) begin
            next_s.w_full = 1'b1;
            next_s.w_data = wdata;
            next_s.w_strb = wstrb;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        // Write commits once both halves are held and the response slot is free
        if (s.aw_full && s.w_full && !s.bvalid) begin
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = wr_err ? `EVC_RESP_SLVERR : `EVC_RESP_OKAY;
            for (int b = 0; b < 4; b++) begin
                if (s.w_strb[b] && s.aw_addr == `EVC_OFS_DFC) begin
                    next_s.dfc[b*8 +: 8] = s.w_data[b*8 +: 8];
                end
            end
            if (s.w_strb[0] && s.aw_addr == `EVC_OFS_CTRL) begin
                next_s.ctrl = s.w_data[`EVC_CTRL_W-1:0];
            end
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd_word;
            next_s.rresp  = rd_err ? `EVC_RESP_SLVERR : `EVC_RESP_OKAY;
        end

        next_s.rst_prev  = rst_lvl;
        next_s.mchk_prev = pin_bus.lvl[`EVC_PIN_MCHK];
        next_s.tea_prev  = pin_bus.lvl[`EVC_PIN_TEA];

        // Dispatch; the vector register never holds the reserved offset once used
        if (want_rst) begin
            next_s.take    = 1'b1;
            next_s.vector  = `EVC_VEC_RESET;
            next_s.cls     = evc_pkg::CLS_ASYNC_NM;
            next_s.precise = 1'b0;
        end else if (want_mchk) begin
            next_s.take    = 1'b1;
            next_s.vector  = `EVC_VEC_MCHK;
            next_s.cls     = evc_pkg::CLS_ASYNC_NM;
            next_s.precise = 1'b0;
        end else if (want_sync) begin
            next_s.take    = 1'b1;
            next_s.cls     = evc_pkg::CLS_SYNC;
            next_s.precise = 1'b1;
            if (instr_storage_fault) begin
                next_s.vector = `EVC_VEC_ISI;
            end else if (align) begin
                next_s.vector = `EVC_VEC_ALIGN;
            end else if (dsi) begin
                next_s.vector = `EVC_VEC_DSI;
                next_s.dfc    = dfc_word;
            end else begin
                // Imprecise fp mode bit is held but never changes delivery
                next_s.vector = `EVC_VEC_PROG;
            end
        end else if (want_async) begin
            next_s.take    = 1'b1;
            next_s.cls     = evc_pkg::CLS_ASYNC_M;
            next_s.precise = 1'b1;
            if (pin_bus.lvl[`EVC_PIN_IRQ]) begin
                next_s.vector = `EVC_VEC_EXT;
            end else if (s.pend_dec) begin
                next_s.vector   = DEC_VECTOR;
                next_s.pend_dec = 1'b0;
            end else begin
                next_s.vector   = SMI_VECTOR;
                next_s.pend_smi = 1'b0;
            end
        end
        // A new event in the clearing cycle is kept
        if (dec_event) begin
            next_s.pend_dec = 1'b1;
        end
        if (smi_event) begin
            next_s.pend_smi = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign awready     = ~s.aw_full;
    assign wready      = ~s.w_full;
    assign bvalid      = s.bvalid;
    assign bresp       = s.bresp;
    assign arready     = ~s.rvalid;
    assign rvalid      = s.rvalid;
    assign rdata       = s.rdata;
    assign rresp       = s.rresp;
    assign exc_take    = s.take;
    assign exc_vector  = s.vector;
    assign exc_class   = s.cls;
    assign exc_precise = s.precise;

    // Checks
    AST_NM_IMPRECISE: assert property (@(posedge aclk) disable iff (!aresetn)
        exc_take && exc_class == evc_pkg::CLS_ASYNC_NM |-> !exc_precise)
        else $error("non-maskable exception marked precise");
    AST_SYNC_PRECISE: assert property (@(posedge aclk) disable iff (!aresetn)
        want_sync |=> exc_take && exc_precise && exc_class == evc_pkg::CLS_SYNC)
        else $error("instruction fault not taken precisely");
    AST_FP_ANY_MODE: assert property (@(posedge aclk) disable iff (!aresetn)
        want_sync && !instr_storage_fault && !align && !dsi |=> exc_precise && exc_vector == `EVC_VEC_PROG)
        else $error("fp exception not delivered precisely");
    AST_RESET_VEC: assert property (@(posedge aclk) disable iff (!aresetn)
        rst_edge |=> exc_take && exc_vector == `EVC_VEC_RESET)
        else $error("reset pin did not vector to system reset");
    AST_NO_RSVD: assert property (@(posedge aclk) disable iff (!aresetn)
        exc_take |-> exc_vector != `EVC_VEC_RSVD)
        else $error("reserved vector issued");
    AST_MCHK: assert property (@(posedge aclk) disable iff (!aresetn)
        !rst_edge && (parity_error || tea_hit) |=> exc_take && exc_vector == `EVC_VEC_MCHK)
        else $error("machine check not taken");
    AST_DFC_CAUSE: assert property (@(posedge aclk) disable iff (!aresetn)
        want_sync && !instr_storage_fault && !align && dsi |=> s.dfc[`EVC_DFC_XLAT] == $past(cmp_xlat_miss)
        && s.dfc[`EVC_DFC_STORE] == $past(cmp_store) && exc_vector == `EVC_VEC_DSI)
        else $error("cause bits not recorded on data fault");
    AST_ISI: assert property (@(posedge aclk) disable iff (!aresetn)
        want_sync && cmp_fetch_miss |=> exc_vector == `EVC_VEC_ISI)
        else $error("fetch miss not vectored to instruction fault");
    AST_EXT_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
        exc_take && exc_vector == `EVC_VEC_EXT |-> $past(ee) && $past(boundary))
        else $error("external interrupt taken while masked or mid-instruction");
    AST_ALIGN_LE: assert property (@(posedge aclk) disable iff (!aresetn)
        want_sync && !instr_storage_fault && le && op == evc_pkg::OP_STRING |=> exc_vector == `EVC_VEC_ALIGN)
        else $error("little-endian string not aligned-trapped");
    AST_ORDER: assert property (@(posedge aclk) disable iff (!aresetn)
        rst_edge && mchk_ev |=> exc_take && exc_vector == `EVC_VEC_RESET)
        else $error("machine check overtook system reset");
    AST_MASKED: assert property (@(posedge aclk) disable iff (!aresetn)
        !ee |=> !(exc_take && exc_class == evc_pkg::CLS_ASYNC_M))
        else $error("maskable exception taken while masked");
    AST_DFC_PROT: assert property (@(posedge aclk) disable iff (!aresetn)
        want_sync && !instr_storage_fault && !align && dsi |=> s.dfc[`EVC_DFC_PROT] == $past(cmp_prot_deny))
        else $error("protection cause bit not recorded");
endmodule

/* File: sim/evc_partner.sv */
`timescale 1ns/1ns
// External event sources: reset pins, machine check, bus error, interrupt
module evc_partner (
    input  wire logic       aclk,
    input  wire logic [4:0] cmd,
    output logic            soft_reset_in,
    output logic            hard_reset_in,
    output logic            machine_check_in,
    output logic            bus_transfer_error,
    output logic            irq_in
);
    logic [4:0] pin_q = 5'h00;

    // Pins follow a command one edge late, on the same aclk the core samples with
    always @(posedge aclk) pin_q <= cmd;
    assign {irq_in, bus_transfer_error, machine_check_in, hard_reset_in, soft_reset_in} = pin_q;
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ns
module testbench;
    localparam logic [19:0] DEC_V = 20'h00f00;
    localparam logic [19:0] SMI_V = 20'h00e00;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, exc_class, cmp_ea_lo = 2'h0, cmp_size = 2'h2;
    logic        awready, wready, bvalid, arready, rvalid, exc_take, exc_precise;
    logic [19:0] exc_vector;
    logic        soft_reset_in, hard_reset_in, machine_check_in, bus_transfer_error, irq_in;
    logic [4:0]  cmd = 5'h00;
    logic        data_bus_active = 1'h0, dec_event = 1'h0, smi_event = 1'h0;
    logic        instr_busy = 1'h1, restart_known = 1'h0, user_mode = 1'h0;
    logic        cmp_valid = 1'h0, cmp_store = 1'h0, supervisor_key = 1'h0, user_key = 1'h0;
    logic [2:0]  cmp_op = 3'h0;
    logic [1:0]  page_protect_bits = 2'h0;
    logic [8:0]  flg = 9'h000;
    logic        parity_error, cmp_fp_exc, cmp_fetch_miss, cmp_cache_inhib, cmp_wt_required;
    logic        cmp_direct_seg, cmp_wt_target, cmp_prot_deny, cmp_xlat_miss;
    int          err_count = 0, n_tests = 0;

    // Per-instruction condition flags packed so a table entry sets them all
    assign {parity_error, cmp_fp_exc, cmp_fetch_miss, cmp_cache_inhib, cmp_wt_required,
            cmp_direct_seg, cmp_wt_target, cmp_prot_deny, cmp_xlat_miss} = flg;

    evc_unit #(.DEC_VECTOR(DEC_V), .SMI_VECTOR(SMI_V)) evc_unit_i (.*);
    evc_partner evc_partner_i (.*);

    always #25 aclk = ~aclk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Bus write: both halves offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1 && n < 40);
        bready <= 1'h0;
        chk("bvalid", bvalid, 32'h1);
        chk("bresp", bresp, er);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1 && n < 40);
        rready <= 1'h0;
        chk("rvalid", rvalid, 32'h1);
        chk("rdata", rdata, ed);
        chk("rresp", rresp, er);
    endtask

    // Bounded wait; a missing pulse shows up as a take mismatch
    task automatic wait_take(input logic [19:0] v, input logic [1:0] c, input logic p);
        int n = 0;
        #1;
        while (exc_take !== 1'h1 && n < 12) begin
            @(posedge aclk);
            #1;
            n++;
        end
        chk("take", exc_take, 32'h1);
        chk("vector", exc_vector, v);
        chk("class", exc_class, c);
        chk("precise", exc_precise, p);
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge aclk);
            #1;
            chk("idle", exc_take, 32'h0);
        end
    endtask

    task automatic cmpl(input logic [2:0] op, input logic st, input logic [1:0] ea,
                        input logic [8:0] f);
        @(posedge aclk);
        cmp_valid <= 1'h1;
        cmp_op <= op;
        cmp_store <= st;
        cmp_ea_lo <= ea;
        flg <= f;
        @(posedge aclk);
        cmp_valid <= 1'h0;
        flg <= 9'h000;
    endtask

    task automatic pin(input int i, input logic [19:0] v);
        @(posedge aclk);
        cmd <= 5'h01 << i;
        wait_take(v, 2'h1, 1'h0);
        @(posedge aclk);
        cmd <= 5'h00;
        repeat (4) @(posedge aclk);
    endtask

    task automatic dsi(input logic [2:0] op, input logic st, input logic [8:0] f,
                       input logic [31:0] e);
        cmpl(op, st, 2'h0, f);
        wait_take(20'h00300, 2'h3, 1'h1);
        rd(8'h00, e, 2'h0);
    endtask

    task automatic al(input logic [2:0] op, input logic [1:0] ea, input logic [8:0] f);
        cmpl(op, 1'h0, ea, f);
        wait_take(20'h00600, 2'h3, 1'h1);
    endtask

    task automatic t_reset;
        rd(8'h04, 32'h0, 2'h0);
        pin(0, 20'h00100);
        pin(1, 20'h00100);
        rd(8'h08, 32'h00000100, 2'h0);
    endtask

    task automatic t_regs;
        wr(8'h00, 32'h12345678, 2'h0);
        rd(8'h00, 32'h12345678, 2'h0);
        wr(8'h08, 32'hffffffff, 2'h2);
        rd(8'h08, 32'h00000100, 2'h0);
        rd(8'h0c, 32'h0, 2'h2);
        wr(8'h04, 32'h8, 2'h0);
        rd(8'h04, 32'h8, 2'h0);
        cmpl(3'h2, 1'h0, 2'h0, 9'h080);
        wait_take(20'h00700, 2'h3, 1'h1);
        wr(8'h04, 32'h0, 2'h0);
    endtask

    task automatic t_mchk;
        pin(2, 20'h00200);
        // Bus error outside a data transaction must be ignored
        @(posedge aclk);
        cmd <= 5'h08;
        quiet(6);
        @(posedge aclk);
        cmd <= 5'h00;
        data_bus_active <= 1'h1;
        pin(3, 20'h00200);
        data_bus_active <= 1'h0;
        cmpl(3'h0, 1'h0, 2'h0, 9'h100);
        wait_take(20'h00200, 2'h1, 1'h0);
    endtask

    task automatic t_dsi;
        dsi(3'h1, 1'h1, 9'h001, 32'h42000000);
        dsi(3'h1, 1'h0, 9'h002, 32'h08000000);
        dsi(3'h1, 1'h0, 9'h008, 32'h04000000);
        dsi(3'h6, 1'h1, 9'h000, 32'h02100000);
        wr(8'h04, 32'h4, 2'h0);
        dsi(3'h6, 1'h0, 9'h004, 32'h04000000);
    endtask

    task automatic t_align;
        al(3'h2, 2'h1, 9'h000);
        al(3'h3, 2'h1, 9'h000);
        al(3'h4, 2'h2, 9'h000);
        al(3'h7, 2'h0, 9'h020);
        al(3'h7, 2'h0, 9'h010);
        cmpl(3'h1, 1'h0, 2'h2, 9'h000);
        quiet(4);
        wr(8'h04, 32'h2, 2'h0);
        al(3'h1, 2'h2, 9'h000);
        al(3'h5, 2'h0, 9'h000);
        al(3'h3, 2'h0, 9'h000);
        wr(8'h04, 32'h0, 2'h0);
    endtask

    task automatic t_isi;
        cmpl(3'h1, 1'h0, 2'h0, 9'h040);
        wait_take(20'h00400, 2'h3, 1'h1);
        @(posedge aclk);
        user_mode <= 1'h1;
        user_key <= 1'h1;
        cmpl(3'h0, 1'h0, 2'h0, 9'h000);
        wait_take(20'h00400, 2'h3, 1'h1);
        @(posedge aclk);
        user_mode <= 1'h0;
        cmpl(3'h0, 1'h0, 2'h0, 9'h000);
        quiet(4);
        @(posedge aclk);
        user_key <= 1'h0;
    endtask

    // Interrupt held while masked, then taken only at an instruction boundary
    task automatic t_irq;
        @(posedge aclk);
        cmd <= 5'h10;
        dec_event <= 1'h1;
        smi_event <= 1'h1;
        @(posedge aclk);
        dec_event <= 1'h0;
        smi_event <= 1'h0;
        cmpl(3'h0, 1'h0, 2'h0, 9'h000);
        quiet(6);
        wr(8'h04, 32'h1, 2'h0);
        rd(8'h08, 32'h00700400, 2'h0);
        quiet(3);
        cmpl(3'h0, 1'h0, 2'h0, 9'h000);
        wait_take(20'h00500, 2'h2, 1'h1);
        @(posedge aclk);
        cmd <= 5'h00;
        repeat (5) @(posedge aclk);
        instr_busy <= 1'h0;
        restart_known <= 1'h1;
        wait_take(DEC_V, 2'h2, 1'h1);
        @(posedge aclk);
        instr_busy <= 1'h1;
        restart_known <= 1'h0;
        wait_take(SMI_V, 2'h2, 1'h1);
        wr(8'h04, 32'h0, 2'h0);
    endtask

    task automatic t_prio;
        cmpl(3'h1, 1'h0, 2'h0, 9'h101);
        wait_take(20'h00200, 2'h1, 1'h0);
        // Reset edge meets a parity error
        @(posedge aclk);
        cmd <= 5'h01;
        repeat (2) @(posedge aclk);
        cmpl(3'h0, 1'h0, 2'h0, 9'h100);
        wait_take(20'h00100, 2'h1, 1'h0);
        @(posedge aclk);
        cmd <= 5'h00;
        repeat (6) @(posedge aclk);
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_regs();
        t_mchk();
        t_dsi();
        t_align();
        t_isi();
        t_irq();
        t_prio();
        report_and_stop();
    end

    // Watchdog, far beyond the few hundred cycles the sequence needs
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
endmodule
